// >>> pms_pkg.sv
// types shared by the motor task scheduler
package pms_pkg;
	typedef logic signed [23:0] pms_fract_t;
	typedef enum logic {PMS_IDLE = 1'b0, PMS_RUN = 1'b1} pms_state_e;
	typedef enum logic [2:0] {
		PMS_T_AS1 = 3'h0,
		PMS_T_SPD = 3'h1,
		PMS_T_BRK = 3'h2,
		PMS_T_AS2 = 3'h3,
		PMS_T_CL1 = 3'h4,
		PMS_T_CL2 = 3'h5,
		PMS_T_VEC = 3'h6,
		PMS_T_PWM = 3'h7
	} pms_task_e;
endpackage

// >>> pms_plant.sv
// model of the power stage, encoder and converter around the scheduler
`timescale 1ns/1ps
module pms_plant (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// scheduler pins
	input wire logic adc_trig_i,
	input wire logic [2:0] pwm_top_i,
	input wire logic [2:0] pwm_base_i,
	// bench commands
	input wire logic [23:0] bus_cmd_i,
	input wire logic [23:0] pos_cmd_i,
	// sensed values
	output logic [23:0] enc_pos_diff_o,
	output logic [23:0] enc_last_edge_o,
	output logic [23:0] bus_volt_o,
	output logic [23:0] cur_d_o,
	output logic [23:0] cur_q_o
);
	logic [23:0] tmr_ff;
	logic [23:0] on_a_ff;
	logic [23:0] on_b_ff;
	logic trig_ff;
	// position delta comes straight from the bench
	assign enc_pos_diff_o = pos_cmd_i;
	// an encoder edge every 100 cycles; the stamp moves only on an edge
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tmr_ff <= 24'h000000;
			enc_last_edge_o <= 24'h000000;
		end else begin
			tmr_ff <= tmr_ff + 24'h000001;
			if (tmr_ff % 100 == 0) begin
				enc_last_edge_o <= tmr_ff;
			end
		end
	end
	// converter samples on the trigger rise, so a new bus level lags a frame
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trig_ff <= 1'b0;
			on_a_ff <= 24'h000000;
			on_b_ff <= 24'h000000;
			bus_volt_o <= 24'h000000;
			cur_d_o <= 24'h000000;
			cur_q_o <= 24'h000000;
		end else begin
			trig_ff <= adc_trig_i;
			if (adc_trig_i && !trig_ff) begin
				bus_volt_o <= bus_cmd_i;
				cur_d_o <= on_a_ff - on_b_ff;
				cur_q_o <= on_b_ff - on_a_ff;
				on_a_ff <= 24'h000000;
				on_b_ff <= 24'h000000;
			end else begin
				on_a_ff <= on_a_ff + {23'h000000, pwm_top_i[0] & ~pwm_base_i[0]};
				on_b_ff <= on_b_ff + {23'h000000, pwm_top_i[1] & ~pwm_base_i[1]};
			end
		end
	end
endmodule

// >>> pms_sched.sv
// motor control task scheduler with wishbone register slave
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pmsm_sched_consts.svh"
// Operation
// - brake off below lower bus level
// - linear brake duty between bus levels
// - brake fully on above upper level
// - brake updates only on link request
// - speed PI on ramped required speed
// - speed from position and edge timestamp
// - speed loop every fourth frame
// - speed then brake before analog thread two
// - trigger high frame start to centre
// - analog thread two at quarter frame
// - two current threads then vector request
// - late activity defers pwm update
// - pwm update starts lead before end
// - vector request serviced after current loop
// - three centre-aligned pairs, base inverted
// - fifty microsecond frame period
// - services run to completion unpreempted
// - service latency under one frame
// - activity pins high during service
// - quantities are 24-bit signed fractions
// - default fraction format 1.23
// - voltage vector in 3.21 format
// - analog task links speed and current
module pms_sched import pms_pkg::*; #(
	parameter int FRAME_CYC = `PMS_FRAME_CYC,
	parameter int SVC_CYC = `PMS_SVC_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// sensed values
	input wire logic [23:0] enc_pos_diff_i,
	input wire logic [23:0] enc_last_edge_i,
	input wire logic [23:0] bus_volt_i,
	input wire logic [23:0] cur_d_i,
	input wire logic [23:0] cur_q_i,
	// drive and debug pins
	output logic adc_trig_o,
	output logic brake_o,
	output logic [2:0] pwm_top_o,
	output logic [2:0] pwm_base_o,
	output logic act_spd_o,
	output logic act_cl_o,
	output logic act_pwm_o
);
	localparam int HALF = FRAME_CYC / 2;
	localparam logic [10:0] HALF_C = 11'(HALF);
	localparam logic [10:0] LAST_C = 11'(FRAME_CYC - 1);
	localparam logic [10:0] QTR_C = 11'(FRAME_CYC / 4);

	// frame and service counters are 11 and 4 bits wide
	if (FRAME_CYC < 16 || FRAME_CYC > 2047 || SVC_CYC < 1 ||
		SVC_CYC > 15) begin : g_bad_par
		$error("pms_sched: unsupported parameters");
	end

	// saturate a wide signed value into a 1.23 fraction
	function automatic pms_fract_t sat24(input logic signed [49:0] x);
		if (x > 50'sh7FFFFF)
			sat24 = `PMS_FR_MAX;
		else if (x < -50'sh800000)
			sat24 = `PMS_FR_MIN;
		else
			sat24 = x[23:0];
	endfunction

	//**********************************************************
	// register slave
	//**********************************************************
	logic en_ff;
	pms_fract_t tgt_ff, blo_ff, bhi_ff, kps_ff, kis_ff, kpc_ff;
	logic [23:0] scl_ff, step_ff;
	logic [10:0] lead_ff;
	logic [15:0] defer_ff;
	pms_fract_t spd_ff, trq_ff;
	logic [1:0] mod_ff;
	logic wr;
	// a write lands at the edge at which the master samples ack
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	// single-cycle answer; ack drops the cycle after it is given
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
	end

	// writes; only full-word writes update any field
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_ff <= 1'b0;
			tgt_ff <= 24'h000000;
			blo_ff <= `PMS_R_BUS_LO;
			bhi_ff <= `PMS_R_BUS_HI;
			lead_ff <= 11'(`PMS_LEAD_CYC);
			kps_ff <= `PMS_R_KP;
			kis_ff <= `PMS_R_KI;
			kpc_ff <= `PMS_R_KP;
			scl_ff <= `PMS_R_SCALE;
			step_ff <= `PMS_R_STEP;
		end else if (wr && wb_sel_i == 4'hF) begin
			case (wb_adr_i)
			`PMS_A_CTRL: en_ff <= wb_dat_i[0];
			`PMS_A_TARGET: tgt_ff <= wb_dat_i[23:0];
			`PMS_A_BUS_LO: blo_ff <= wb_dat_i[23:0];
			`PMS_A_BUS_HI: bhi_ff <= wb_dat_i[23:0];
			`PMS_A_LEAD: lead_ff <= wb_dat_i[10:0];
			`PMS_A_KP_SPD: kps_ff <= wb_dat_i[23:0];
			`PMS_A_KI_SPD: kis_ff <= wb_dat_i[23:0];
			`PMS_A_KP_CUR: kpc_ff <= wb_dat_i[23:0];
			`PMS_A_SCALE: scl_ff <= wb_dat_i[23:0];
			`PMS_A_STEP: step_ff <= wb_dat_i[23:0];
			default: ;
			endcase
		end
	end

	// read mux; unmapped words read zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			wb_dat_o <= 32'h00000000;
		else begin
			case (wb_adr_i)
			`PMS_A_CTRL: wb_dat_o <= {31'h0, en_ff};
			`PMS_A_TARGET: wb_dat_o <= {8'h0, tgt_ff};
			`PMS_A_BUS_LO: wb_dat_o <= {8'h0, blo_ff};
			`PMS_A_BUS_HI: wb_dat_o <= {8'h0, bhi_ff};
			`PMS_A_LEAD: wb_dat_o <= {21'h0, lead_ff};
			`PMS_A_KP_SPD: wb_dat_o <= {8'h0, kps_ff};
			`PMS_A_KI_SPD: wb_dat_o <= {8'h0, kis_ff};
			`PMS_A_KP_CUR: wb_dat_o <= {8'h0, kpc_ff};
			`PMS_A_SCALE: wb_dat_o <= {8'h0, scl_ff};
			`PMS_A_STEP: wb_dat_o <= {8'h0, step_ff};
			`PMS_A_STATUS: wb_dat_o <= {14'h0, mod_ff, defer_ff};
			`PMS_A_SPEED: wb_dat_o <= {8'h0, spd_ff};
			`PMS_A_TORQUE: wb_dat_o <= {8'h0, trq_ff};
			default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	//**********************************************************
	// frame timebase
	//**********************************************************
	logic [10:0] cnt_ff;
	logic fstart, as2_t, pwm_t;
	assign fstart = en_ff && cnt_ff == 11'h000;
	assign as2_t = en_ff && cnt_ff == QTR_C;
	assign pwm_t = en_ff && cnt_ff == LAST_C - lead_ff;

	// frame counter wraps every period; cleared to zero while disabled
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			cnt_ff <= 11'h000;
		else if (!en_ff || cnt_ff == LAST_C)
			cnt_ff <= 11'h000;
		else
			cnt_ff <= cnt_ff + 11'h001;
	end

	// modulo-four frame index, restarted with the timebase
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			mod_ff <= 2'h0;
		else if (!en_ff)
			mod_ff <= 2'h0;
		else if (cnt_ff == LAST_C)
			mod_ff <= mod_ff + 2'h1;
	end

	// converter trigger from frame start to frame centre
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			adc_trig_o <= 1'b0;
		else
			adc_trig_o <= en_ff && (cnt_ff == LAST_C ||
				cnt_ff < HALF_C - 11'h001);
	end

	//**********************************************************
	// service engine
	//**********************************************************
	pms_state_e st_ff;
	pms_task_e tsk_ff, nxt_tsk;
	logic [7:0] pend_ff, done_ff, set_m, clr_m, need;
	logic [3:0] sc_ff;
	logic svc_end, go, all_done;
	assign svc_end = st_ff == PMS_RUN && sc_ff == 4'(SVC_CYC - 1);
	assign go = st_ff == PMS_IDLE && pend_ff != 8'h00;

	// fixed priority: lowest task index wins
	always_comb begin
		nxt_tsk = PMS_T_PWM;
		for (int i = 7; i >= 0; i--)
			if (pend_ff[i])
				nxt_tsk = pms_task_e'(3'(i));
	end

	// links raised by frame timing and by finishing services
	always_comb begin
		set_m = 8'h00;
		clr_m = 8'h00;
		set_m[PMS_T_AS1] = fstart;
		set_m[PMS_T_SPD] = svc_end && tsk_ff == PMS_T_AS1 &&
			mod_ff == 2'h0;
		set_m[PMS_T_BRK] = svc_end && tsk_ff == PMS_T_SPD;
		set_m[PMS_T_AS2] = as2_t;
		set_m[PMS_T_CL1] = svc_end && tsk_ff == PMS_T_AS2;
		set_m[PMS_T_CL2] = svc_end && tsk_ff == PMS_T_CL1;
		set_m[PMS_T_VEC] = svc_end && tsk_ff == PMS_T_CL2;
		set_m[PMS_T_PWM] = pwm_t && all_done;
		if (go)
			clr_m[nxt_tsk] = 1'b1;
	end

	// pending requests; a new link wins over the clear
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			pend_ff <= 8'h00;
		else if (!en_ff)
			pend_ff <= 8'h00;
		else
			pend_ff <= (pend_ff & ~clr_m) | set_m;
	end

	// activities expected done before the pwm update
	always_comb begin
		need = 8'h00;
		need[PMS_T_AS2] = 1'b1;
		need[PMS_T_CL2] = 1'b1;
		need[PMS_T_VEC] = 1'b1;
		need[PMS_T_SPD] = mod_ff == 2'h0;
		need[PMS_T_BRK] = mod_ff == 2'h0;
	end
	assign all_done = (done_ff & need) == need;

	// completion flags, cleared at each frame start
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			done_ff <= 8'h00;
		else if (fstart)
			done_ff <= 8'h00;
		else if (svc_end)
			done_ff[tsk_ff] <= 1'b1;
	end

	// deferred pwm updates, counted for software
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			defer_ff <= 16'h0000;
		else if (pwm_t && !all_done)
			defer_ff <= defer_ff + 16'h0001;
	end

	// a started service runs its full length before the next
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= PMS_IDLE;
			tsk_ff <= PMS_T_AS1;
			sc_ff <= 4'h0;
		end else begin
			case (st_ff)
			PMS_IDLE: begin
				sc_ff <= 4'h0;
				if (go) begin
					st_ff <= PMS_RUN;
					tsk_ff <= nxt_tsk;
				end
			end
			PMS_RUN: begin
				sc_ff <= sc_ff + 4'h1;
				if (svc_end)
					st_ff <= PMS_IDLE;
			end
			default: st_ff <= PMS_IDLE;
			endcase
		end
	end

	// activity pins follow the service window exactly
	assign act_spd_o = st_ff == PMS_RUN && tsk_ff == PMS_T_SPD;
	assign act_cl_o = st_ff == PMS_RUN &&
		(tsk_ff == PMS_T_CL1 || tsk_ff == PMS_T_CL2);
	assign act_pwm_o = st_ff == PMS_RUN &&
		(tsk_ff == PMS_T_VEC || tsk_ff == PMS_T_PWM);

	//**********************************************************
	// speed loop and brake chopper
	//**********************************************************
	logic [23:0] edge_ff, bduty_ff;
	pms_fract_t ramp_ff, int_ff, err_s, nxt_ramp;
	logic [23:0] td;
	logic signed [49:0] w_spd, w_p, w_i;
	pms_fract_t nxt_spd, nxt_int;
	logic spd_go, brk_go;
	assign spd_go = go && nxt_tsk == PMS_T_SPD;
	assign brk_go = go && nxt_tsk == PMS_T_BRK;
	assign td = enc_last_edge_i - edge_ff;

	// speed, ramp and PI step in one activation
	always_comb begin
		w_spd = 50'(signed'(enc_pos_diff_i)) * 50'(signed'({1'b0, scl_ff}));
		if (td == 24'h000000)
			nxt_spd = spd_ff;
		else
			nxt_spd = sat24(w_spd / 50'(signed'({1'b0, td})));
		if (ramp_ff < tgt_ff)
			nxt_ramp = sat24(50'(ramp_ff) + 50'(signed'({1'b0, step_ff})));
		else
			nxt_ramp = sat24(50'(ramp_ff) - 50'(signed'({1'b0, step_ff})));
		if ((ramp_ff < tgt_ff) != (nxt_ramp < tgt_ff))
			nxt_ramp = tgt_ff;
		err_s = sat24(50'(nxt_ramp) - 50'(nxt_spd));
		w_p = (50'(kps_ff) * 50'(err_s)) >>> 23;
		w_i = (50'(kis_ff) * 50'(err_s)) >>> 23;
		nxt_int = sat24(50'(int_ff) + w_i);
		w_p = w_p + 50'(nxt_int);
	end

	// speed state is taken at the start of its service
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			edge_ff <= 24'h000000;
			spd_ff <= 24'h000000;
			ramp_ff <= 24'h000000;
			int_ff <= 24'h000000;
			trq_ff <= 24'h000000;
		end else if (spd_go) begin
			edge_ff <= enc_last_edge_i;
			spd_ff <= nxt_spd;
			ramp_ff <= nxt_ramp;
			int_ff <= nxt_int;
			trq_ff <= sat24(w_p);
		end
	end

	// brake duty re-evaluated only when its link is serviced
	logic [47:0] w_b;
	logic [23:0] span;
	always_comb begin
		span = bhi_ff - blo_ff;
		w_b = 48'(bus_volt_i - blo_ff) * 48'(FRAME_CYC);
		if (span == 24'h000000)
			w_b = 48'h0;
		else
			w_b = w_b / 48'(span);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			bduty_ff <= 24'h000000;
		else if (brk_go) begin
			if ($signed(bus_volt_i) < blo_ff)
				bduty_ff <= 24'h000000;
			else if ($signed(bus_volt_i) >= bhi_ff)
				bduty_ff <= 24'(FRAME_CYC);
			else
				bduty_ff <= w_b[23:0];
		end
	end

	// brake pwm against the frame counter
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			brake_o <= 1'b0;
		else
			brake_o <= {13'h0, cnt_ff} < bduty_ff;
	end

	//**********************************************************
	// current loop, vector update and phase pwm
	//**********************************************************
	pms_fract_t id_ff, iq_ff, ed_ff, eq_ff, va_ff, vb_ff;
	logic [10:0] shd_ff [3];
	logic [10:0] act_ff [3];
	pms_fract_t ph [3];

	// analog thread two latches the preprocessed currents
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			id_ff <= 24'h000000;
			iq_ff <= 24'h000000;
			ed_ff <= 24'h000000;
			eq_ff <= 24'h000000;
			va_ff <= 24'h000000;
			vb_ff <= 24'h000000;
		end else if (go) begin
			case (nxt_tsk)
			PMS_T_AS2: begin
				id_ff <= cur_d_i;
				iq_ff <= cur_q_i;
			end
			PMS_T_CL1: begin
				ed_ff <= sat24(-50'(id_ff));
				eq_ff <= sat24(50'(trq_ff) - 50'(iq_ff));
			end
			PMS_T_CL2: begin
				// 1.23 result shifted two places into 3.21
				va_ff <= sat24((50'(kpc_ff) * 50'(ed_ff)) >>> 25);
				vb_ff <= sat24((50'(kpc_ff) * 50'(eq_ff)) >>> 25);
			end
			default: ;
			endcase
		end
	end

	// inverse Clarke of the applied vector
	logic signed [49:0] w_bb;
	always_comb begin
		w_bb = (50'(vb_ff) * 50'(signed'(`PMS_SQRT3_2))) >>> 23;
		ph[0] = va_ff;
		ph[1] = sat24(w_bb - (50'(va_ff) >>> 1));
		ph[2] = sat24(-50'(va_ff) - 50'(ph[1]));
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ph
			logic signed [49:0] w_d;
			// unit voltage in 3.21 spans the full half period
			always_comb begin
				w_d = 50'(HALF / 2) + ((50'(ph[g]) * 50'(HALF)) >>>
					23) * 50'sd2;
				if (w_d < 50'sd0)
					w_d = 50'sd0;
				else if (w_d > 50'(HALF))
					w_d = 50'(HALF);
			end

			// second current thread computes the vector, long update loads shadow
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i)
					shd_ff[g] <= 11'(HALF / 2);
				else if (go && nxt_tsk == PMS_T_PWM)
					shd_ff[g] <= w_d[10:0];
			end

			// shadow takes effect at the next frame start
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i)
					act_ff[g] <= 11'(HALF / 2);
				else if (fstart)
					act_ff[g] <= shd_ff[g];
			end

			// centre-aligned pair, base channel inverted
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					pwm_top_o[g] <= 1'b0;
					pwm_base_o[g] <= 1'b1;
				end else begin
					pwm_top_o[g] <= en_ff && ((cnt_ff < HALF_C) ?
						(HALF_C - cnt_ff) : (cnt_ff - HALF_C)) <
						act_ff[g];
					pwm_base_o[g] <= !(en_ff && ((cnt_ff < HALF_C) ?
						(HALF_C - cnt_ff) : (cnt_ff - HALF_C)) <
						act_ff[g]);
				end
			end
		end
	endgenerate

	//**********************************************************
	// checks
	//**********************************************************
	AST_BRK_LOW: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		brk_go && $signed(bus_volt_i) < blo_ff |=> bduty_ff == 24'h000000)
		else $error("brake duty not zero below lower level");
	AST_BRK_HIGH: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		brk_go && $signed(bus_volt_i) >= bhi_ff |=> ##1 brake_o)
		else $error("brake not on above upper level");
	AST_BRK_LINK: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		!brk_go |=> $stable(bduty_ff))
		else $error("brake duty changed without link");
	// the speed service itself, not its request, is held to the frame
	AST_SPD_FRAME: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(act_spd_o) |-> mod_ff == 2'h0)
		else $error("speed service outside fourth frame");
	// bound covers one running service, the first analog thread and gaps
	AST_SPD_RUN: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		fstart && mod_ff == 2'h0 |-> ##[1:40] act_spd_o)
		else $error("speed service missing in fourth frame");
	AST_SPD_BRK: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		$fell(act_spd_o) |-> pend_ff[PMS_T_BRK])
		else $error("brake not linked after speed loop");
	AST_TRIG: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		fstart && en_ff ##1 en_ff |-> adc_trig_o)
		else $error("trigger low at frame start");
	AST_VEC: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		svc_end && tsk_ff == PMS_T_CL2 |=> pend_ff[PMS_T_VEC])
		else $error("vector request missing after current loop");
	AST_DEFER: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		pwm_t && !all_done |=> !pend_ff[PMS_T_PWM])
		else $error("pwm update not deferred");
	AST_PAIR: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		pwm_top_o == ~pwm_base_o)
		else $error("phase pair not complementary");
	AST_NOPRE: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		st_ff == PMS_RUN && !svc_end |=> st_ff == PMS_RUN &&
		$stable(tsk_ff))
		else $error("service preempted");
endmodule

// >>> pms_sched_test.sv
// self-checking bench for the motor task scheduler
`timescale 1ns/1ps
`include "pmsm_sched_consts.svh"
module pms_sched_test;
	localparam int FRM = `PMS_FRAME_CYC;
	localparam int SVC = `PMS_SVC_CYC;
	localparam int LEAD = `PMS_LEAD_CYC;
	logic clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, s0;
	logic adc_trig_o, brake_o, act_spd_o, act_cl_o, act_pwm_o;
	logic [2:0] pwm_top_o, pwm_base_o;
	logic [23:0] pos_d, last_e, bus_v, cur_d, cur_q, bus_cmd, pos_cmd;
	int n_errors = 0;
	int n_checks = 0;
	int n_cyc = 0;
	int k, trg_r, trg_h, spd_h, cl_h, pwm_h, brk_h, bad_h;
	int top_h [3];
	// register map with reset values; the last entry is unmapped
	logic [5:0] ra [14] = '{`PMS_A_CTRL, `PMS_A_TARGET, `PMS_A_BUS_LO,
		`PMS_A_BUS_HI, `PMS_A_LEAD, `PMS_A_KP_SPD, `PMS_A_KI_SPD,
		`PMS_A_KP_CUR, `PMS_A_SCALE, `PMS_A_STEP, `PMS_A_STATUS,
		`PMS_A_SPEED, `PMS_A_TORQUE, 6'h3C};
	logic [31:0] rv [14] = '{32'h0, 32'h0, {8'h00, `PMS_R_BUS_LO},
		{8'h00, `PMS_R_BUS_HI}, 32'(LEAD), {8'h00, `PMS_R_KP},
		{8'h00, `PMS_R_KI}, {8'h00, `PMS_R_KP}, {8'h00, `PMS_R_SCALE},
		{8'h00, `PMS_R_STEP}, 32'h0, 32'h0, 32'h0, 32'h0};

	// ****************************************
	// design, plant and clock
	// ****************************************
	pms_sched #(.FRAME_CYC(FRM), .SVC_CYC(SVC)) i_pms_sched (
		.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .enc_pos_diff_i(pos_d), .enc_last_edge_i(last_e),
		.bus_volt_i(bus_v), .cur_d_i(cur_d), .cur_q_i(cur_q),
		.adc_trig_o(adc_trig_o), .brake_o(brake_o), .pwm_top_o(pwm_top_o),
		.pwm_base_o(pwm_base_o), .act_spd_o(act_spd_o), .act_cl_o(act_cl_o),
		.act_pwm_o(act_pwm_o));
	pms_plant i_pms_plant (
		.clk_i(clk_i), .rstn_i(rstn_i), .adc_trig_i(adc_trig_o),
		.pwm_top_i(pwm_top_o), .pwm_base_i(pwm_base_o), .bus_cmd_i(bus_cmd),
		.pos_cmd_i(pos_cmd), .enc_pos_diff_o(pos_d), .enc_last_edge_o(last_e),
		.bus_volt_o(bus_v), .cur_d_o(cur_d), .cur_q_o(cur_q));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// the whole run needs about 44000 cycles
	always @(posedge clk_i) begin
		n_cyc <= n_cyc + 1;
		if (n_cyc == 80000) begin
			n_errors++;
			results;
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task results;
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task rng(input string what, input int v, lo, hi);
		n_checks++;
		if (v < lo || v > hi) begin
			n_errors++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, v);
		end
	endtask
	// one classic cycle; the request stands until ack is sampled
	task wb_xfer(input logic we, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		// only the run timeout ends a hang; ack comes one cycle after taking
		check("bus answer", 32'(n), 32'h00000002);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: pick = adc_trig_o;
			1: pick = act_spd_o;
			default: pick = act_pwm_o;
		endcase
	endfunction
	// rise of trigger or pwm activity, fall of speed activity; n = cycles
	task wait_edge(input int s, output int n);
		logic p, c;
		bit hit;
		p = pick(s);
		n = 0;
		hit = 0;
		while (!hit && n < 6000) begin
			@(posedge clk_i);
			c = pick(s);
			n++;
			hit = (s == 1) ? (p === 1'b1 && c === 1'b0) : (!p && c === 1'b1);
			p = c;
		end
		if (!hit) check("edge wait", 32'h0, 32'h1);
	endtask
	// count high cycles of every pin except the base channels over whole frames
	task run_frames(input int n);
		logic pt;
		{trg_r, trg_h, spd_h, cl_h, pwm_h, brk_h, bad_h} = '0;
		top_h = '{0, 0, 0};
		pt = adc_trig_o;
		repeat (n * FRM) begin
			@(posedge clk_i);
			trg_r += (adc_trig_o === 1'b1 && pt === 1'b0);
			pt = adc_trig_o;
			trg_h += (adc_trig_o === 1'b1);
			spd_h += (act_spd_o === 1'b1);
			cl_h += (act_cl_o === 1'b1);
			pwm_h += (act_pwm_o === 1'b1);
			brk_h += (brake_o === 1'b1);
			bad_h += (pwm_base_o !== ~pwm_top_o);
			for (int j = 0; j < 3; j++) top_h[j] += (pwm_top_o[j] === 1'b1);
		end
	endtask
	// fresh bus sample, then past the speed and brake services
	task brake_sync;
		wait_edge(0, k);
		wait_edge(1, k);
		repeat (2 * SVC + 4) @(posedge clk_i);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 6'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		rstn_i = 1'b0;
		bus_cmd = 24'h100000;
		pos_cmd = 24'h000000;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		check("idle pins", {21'h000000, adc_trig_o, brake_o, pwm_top_o,
			pwm_base_o, act_spd_o, act_cl_o, act_pwm_o}, 32'h00000038);
		for (int i = 0; i < 14; i++) begin
			wb_xfer(1'b0, ra[i], 32'h0, 4'hF);
			check("reset value", rd, rv[i]);
		end
		// status is read-only, the hole holds nothing, partial writes drop
		wb_xfer(1'b1, `PMS_A_STATUS, 32'hFFFFFFFF, 4'hF);
		wb_xfer(1'b1, 6'h3C, 32'hFFFFFFFF, 4'hF);
		wb_xfer(1'b1, `PMS_A_LEAD, 32'h000007FF, 4'h3);
		for (int i = 10; i < 14; i += 3) begin
			wb_xfer(1'b0, ra[i], 32'h0, 4'hF);
			check("untouched", rd, 32'h0);
		end
		wb_xfer(1'b0, `PMS_A_LEAD, 32'h0, 4'hF);
		check("lead kept", rd, 32'(LEAD));
		wb_xfer(1'b1, `PMS_A_SCALE, 32'h007FFFFF, 4'hF);
		wb_xfer(1'b0, `PMS_A_SCALE, 32'h0, 4'hF);
		check("scale written", rd, 32'h007FFFFF);
		wb_xfer(1'b1, `PMS_A_CTRL, 32'h00000001, 4'hF);
		run_frames(2);
		// activity per frame and frame timing
		wait_edge(0, k);
		run_frames(4);
		check("trigger rises", trg_r, 4);
		rng("trigger high", trg_h, 4 * 623, 4 * 626);
		check("speed activity", spd_h, SVC);
		check("current activity", cl_h, 8 * SVC);
		check("pwm activity", pwm_h, 8 * SVC);
		check("complement", bad_h, 0);
		for (int j = 0; j < 3; j++) rng("phase on", top_h[j], 1, 4 * FRM - 1);
		wait_edge(0, k);
		check("frame period", k, FRM);
		wait_edge(2, k);
		wait_edge(2, k);
		wait_edge(0, k);
		rng("update lead", k, LEAD - 2, LEAD + 3);
		// update deferral when the lead reaches before analog thread two
		wb_xfer(1'b0, `PMS_A_STATUS, 32'h0, 4'hF);
		s0 = rd;
		run_frames(2);
		wb_xfer(1'b0, `PMS_A_STATUS, 32'h0, 4'hF);
		check("no deferral", {16'h0, rd[15:0]}, {16'h0, s0[15:0]});
		wb_xfer(1'b1, `PMS_A_LEAD, 32'd1100, 4'hF);
		wait_edge(0, k);
		wb_xfer(1'b0, `PMS_A_STATUS, 32'h0, 4'hF);
		s0 = rd;
		run_frames(3);
		check("vector only", pwm_h, 3 * SVC);
		wb_xfer(1'b0, `PMS_A_STATUS, 32'h0, 4'hF);
		check("deferrals", {16'h0, rd[15:0]}, {16'h0, s0[15:0] + 16'h0003});
		check("frame mod4", {30'h0, rd[17:16]}, {30'h0, s0[17:16] + 2'h3});
		wb_xfer(1'b1, `PMS_A_LEAD, 32'(LEAD), 4'hF);
		// brake chopper levels, and no change between link requests
		bus_cmd <= 24'h700000;
		brake_sync;
		run_frames(1);
		check("brake full", brk_h, FRM);
		bus_cmd <= 24'h100000;
		run_frames(2);
		check("brake held", brk_h, 2 * FRM);
		brake_sync;
		run_frames(1);
		check("brake off", brk_h, 0);
		bus_cmd <= 24'h500000;
		brake_sync;
		run_frames(1);
		rng("brake half", brk_h, FRM / 2 - 2, FRM / 2 + 2);
		// measured speed saturates both ways
		bus_cmd <= 24'h100000;
		pos_cmd <= 24'h100000;
		run_frames(5);
		wb_xfer(1'b0, `PMS_A_SPEED, 32'h0, 4'hF);
		check("speed top", rd, 32'h007FFFFF);
		pos_cmd <= 24'hF00000;
		run_frames(5);
		wb_xfer(1'b0, `PMS_A_SPEED, 32'h0, 4'hF);
		check("speed bottom", rd, 32'h00800000);
		results;
	end
endmodule

// >>> pmsm_sched_consts.svh
// constants for the motor task scheduler: timing, offsets, reset values
`ifndef PMSM_SCHED_CONSTS_SVH
`define PMSM_SCHED_CONSTS_SVH
`define PMS_CLK_KHZ 25000
`define PMS_FRAME_NS 50000
`define PMS_FRAME_CYC ((`PMS_FRAME_NS * `PMS_CLK_KHZ) / 1000000)
`define PMS_LEAD_NS 10000
`define PMS_LEAD_CYC ((`PMS_LEAD_NS * `PMS_CLK_KHZ) / 1000000)
`define PMS_SVC_CYC 8
`define PMS_SPD_DIV 4
`define PMS_A_CTRL 6'h00
`define PMS_A_TARGET 6'h04
`define PMS_A_BUS_LO 6'h08
`define PMS_A_BUS_HI 6'h0C
`define PMS_A_LEAD 6'h10
`define PMS_A_KP_SPD 6'h14
`define PMS_A_KI_SPD 6'h18
`define PMS_A_KP_CUR 6'h1C
`define PMS_A_SCALE 6'h20
`define PMS_A_STEP 6'h24
`define PMS_A_STATUS 6'h28
`define PMS_A_SPEED 6'h2C
`define PMS_A_TORQUE 6'h30
`define PMS_R_BUS_LO 24'h400000
`define PMS_R_BUS_HI 24'h600000
`define PMS_R_KP 24'h100000
`define PMS_R_KI 24'h010000
`define PMS_R_SCALE 24'h000100
`define PMS_R_STEP 24'h000400
`define PMS_FR_MAX 24'h7FFFFF
`define PMS_FR_MIN 24'h800000
`define PMS_SQRT3_2 24'h6ED9EC
`define PMS_UNIT_321 24'h200000
`endif
